// *** logic/scas_pkg.sv ***
// Shared constants and types for the start-up configuration and address select block
package scas_pkg;

  // ----------------------------------------------------------------------
  // Configuration store layout
  // ----------------------------------------------------------------------
  localparam int             NV_WORDS        = 7;      // Words copied per load cycle
  localparam int             NV_AW           = 3;      // Word index width
  localparam int             NV_DW           = 8;      // Word width
  localparam logic [2:0]     IDX_I2C_BASE    = 3'h0;   // I2C base address word
  localparam logic [2:0]     IDX_PMBUS_BASE  = 3'h1;   // PMBus base address word
  localparam logic [2:0]     IDX_VIN_ON      = 3'h2;   // Lockout turn-on threshold
  localparam logic [2:0]     IDX_VIN_OFF     = 3'h3;   // Lockout turn-off threshold
  localparam logic [2:0]     IDX_VIN_OV      = 3'h4;   // Input overvoltage fault limit
  localparam logic [2:0]     IDX_VIN_UV      = 3'h5;   // Input undervoltage warning limit
  localparam logic [2:0]     IDX_EN_OPT      = 3'h6;   // Software enable options
  localparam logic [2:0]     IDX_LAST        = 3'h6;   // Last word of a load cycle

  // ----------------------------------------------------------------------
  // Reset values of the working registers
  // ----------------------------------------------------------------------
  localparam logic [6:0]     I2C_BASE_RST    = 7'h10;
  localparam logic [6:0]     PMBUS_BASE_RST  = 7'h40;
  localparam logic [7:0]     VIN_ON_RST      = 8'h20;  // Code of the 1 V default
  localparam logic [7:0]     VIN_OFF_RST     = 8'h1c;
  localparam logic [7:0]     VIN_OV_RST      = 8'hff;
  localparam logic [7:0]     VIN_UV_RST      = 8'h00;
  localparam logic [7:0]     EN_OPT_RST      = 8'h00;

  // ----------------------------------------------------------------------
  // Enable option field positions
  // ----------------------------------------------------------------------
  localparam int             EN_SW_SEL_BIT   = 0;      // Software enable replaces pin rule
  localparam int             EN_SW_ON_BIT    = 1;      // Software on command
  localparam int             EN_PIN_IGN_BIT  = 2;      // Ignore enable pin when software

  // ----------------------------------------------------------------------
  // Address offset ADC decode
  // ----------------------------------------------------------------------
  localparam int             ADC_W           = 10;
  localparam int             OFS_BINS        = 16;
  localparam logic [9:0]     OFS_BIN_CODES   = 10'h03c; // Codes per offset bin
  localparam logic [9:0]     FLOAT_CODE      = 10'h3c0; // Pin floating at or above

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic {IF_I2C, IF_PMBUS} scas_iface_e;

  typedef enum logic [2:0] {
    ST_POR, ST_LOAD_REQ, ST_LOAD_WAIT, ST_ADC_REQ, ST_ADC_WAIT, ST_RUN
  } scas_state_e;

  typedef struct packed {
    scas_iface_e iface;  // Interface the command came on
    logic [6:0]  addr;   // Target address of the transaction
    logic [2:0]  sel;    // Working register index
    logic [7:0]  data;   // New value
  } scas_cmd_s;

  typedef struct packed {
    logic [7:0] vin_on;
    logic [7:0] vin_off;
    logic [7:0] vin_ov;
    logic [7:0] vin_uv;
  } scas_thr_s;

endpackage

// *** logic/scas_sync.sv ***
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module scas_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;  // First stage, read only by the second

  // ----------------------------------------------------------------------
  // Sync chain
  // ----------------------------------------------------------------------
  // Both stages clear to zero so all monitors read as not good in reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// *** logic/scas_offset_decode.sv ***
// Address offset decode from the 10 bit ADC reading of the offset pin
`timescale 1ns/1ps
module scas_offset_decode
  import scas_pkg::*;
(
  // Reading
  input  wire logic [ADC_W-1:0] code,
  // Decode
  output logic      [3:0]       offset,
  output logic                  floating
);

  logic [OFS_BINS-2:0] above;  // One bit per bin boundary passed

  // ----------------------------------------------------------------------
  // Bin boundaries
  // ----------------------------------------------------------------------
  // Higher resistance gives a higher code, so offsets rise with the code
  for (genvar i = 0; i < OFS_BINS - 1; i++) begin : g_bound
    localparam logic [ADC_W-1:0] BOUND = ADC_W'((i + 1) * OFS_BIN_CODES);
    assign above[i] = (code >= BOUND);
  end

  // ----------------------------------------------------------------------
  // Count passed boundaries
  // ----------------------------------------------------------------------
  always_comb begin
    offset = 4'h0;
    for (int j = 0; j < OFS_BINS - 1; j++) begin
      offset = offset + {3'h0, above[j]};
    end
    floating = (code >= FLOAT_CODE);
  end

endmodule

// *** logic/scas_top.sv ***
// Start-up sequencing, configuration load and bus address select
//
// Notes on behaviour
// - Reset held until supplies and oscillator good
// - Copy whole store before further start-up
// - After load and address read, accept writes regardless of enable
// - Default enable needs pin, input, load, address
// - Separate 7-bit I2C and PMBus bases
// - Zero base disables that interface
// - Bases default 0x10, 0x40 plus offset
// - Decode ADC reading into offsets 0..15
// - Respond only to base plus offset
// - Floating pin: analog mode, no bus
// - Analog mode keeps loaded configuration fixed
// - Start needs input lockout and enable comparator
// - Lockout thresholds rewritable by on/off commands
// - Digitised input feeds telemetry only
// - Lockout and input flags come from comparators
// - Software enable options replace pin rule in digital mode
`timescale 1ns/1ps
module scas_top
  import scas_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Supply and oscillator monitors, asynchronous
  input  wire logic               bias_supply_ok,
  input  wire logic               internal_core_supply_ok,
  input  wire logic               osc_stable,
  // Analog comparators, asynchronous
  input  wire logic               enable_force_ccm_pin_cmp,
  input  wire logic               vin_above_on_cmp,
  input  wire logic               vin_below_off_cmp,
  input  wire logic               vin_ov_cmp,
  input  wire logic               vin_uv_warn_cmp,
  // Configuration store read port
  output logic                    nv_rd_req,
  output logic [NV_AW-1:0]        nv_rd_addr,
  input  wire logic               nv_rd_valid,
  input  wire logic [NV_DW-1:0]   nv_rd_data,
  // Offset pin ADC
  output logic                    adc_start,
  input  wire logic               adc_valid,
  input  wire logic [ADC_W-1:0]   adc_code,
  // Input voltage ADC
  input  wire logic               vin_adc_valid,
  input  wire logic [ADC_W-1:0]   vin_adc_code,
  // Bus command port
  input  wire logic               cmd_valid,
  input  wire scas_cmd_s          cmd,
  output logic                    cmd_ack,
  output logic                    cmd_reject,
  // Start-up status
  output logic                    por_active,
  output logic                    load_done,
  output logic                    addr_read,
  output logic                    analog_mode,
  output logic                    comm_pins_analog,
  // Bus addressing
  output logic                    i2c_comm_en,
  output logic                    pmbus_comm_en,
  output logic [6:0]              i2c_addr_eff,
  output logic [6:0]              pmbus_addr_eff,
  // Input monitoring
  output scas_thr_s               thr,
  output logic [ADC_W-1:0]        read_vin,
  output logic                    undervoltage_lockout,
  output logic                    vin_ov_fault,
  output logic                    vin_uv_warn,
  // Power conversion
  output logic                    conv_enable
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  scas_state_e     state_reg;        // Start-up sequencer state
  scas_state_e     state_next;
  logic [2:0]      mon_s;            // Synced supply and oscillator monitors
  logic [4:0]      cmp_s;            // Synced comparators
  logic            supplies_good;    // All monitors good
  logic [6:0]      i2c_base_reg;     // I2C base address
  logic [6:0]      pmbus_base_reg;   // PMBus base address
  logic [7:0]      en_opt_reg;       // Software enable options
  logic [3:0]      offset_reg;       // Latched address offset
  logic [3:0]      dec_offset;       // Decoder output
  logic            dec_float;        // Decoder floating flag
  logic            vin_ok_reg;       // Lockout released
  logic            wr_en;            // Store word or command write strobe
  logic [2:0]      wr_sel;
  logic [7:0]      wr_data;
  logic            cmd_ok;           // Command passes all checks
  logic            run_conv;         // Next conversion enable

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  scas_sync #(.W(3)) u_mon_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({bias_supply_ok, internal_core_supply_ok, osc_stable}),
    .q        (mon_s)
  );

  scas_sync #(.W(5)) u_cmp_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({enable_force_ccm_pin_cmp, vin_above_on_cmp, vin_below_off_cmp,
                vin_ov_cmp, vin_uv_warn_cmp}),
    .q        (cmp_s)
  );

  scas_offset_decode u_dec (
    .code     (adc_code),
    .offset   (dec_offset),
    .floating (dec_float)
  );

  assign supplies_good = &mon_s;

  // ----------------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------------
  // Any monitor dropping sends the sequencer back to reset
  always_comb begin
    state_next = state_reg;
    if (!supplies_good) begin
      state_next = ST_POR;
    end else begin
      case (state_reg)
        ST_POR:       state_next = ST_LOAD_REQ;
        ST_LOAD_REQ:  state_next = ST_LOAD_WAIT;
        ST_LOAD_WAIT: begin
          // Next step only after the last word arrived
          if (nv_rd_valid && nv_rd_addr == IDX_LAST) begin
            state_next = ST_ADC_REQ;
          end else if (nv_rd_valid) begin
            state_next = ST_LOAD_REQ;
          end
        end
        ST_ADC_REQ:   state_next = ST_ADC_WAIT;
        ST_ADC_WAIT: begin
          if (adc_valid) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN:       state_next = ST_RUN;
        default:      state_next = ST_POR;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset indication towards the rest of the chip
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      por_active <= 1'b1;
    end else begin
      por_active <= !supplies_good;
    end
  end

  // ----------------------------------------------------------------------
  // Store read requests
  // ----------------------------------------------------------------------
  // One word in flight at a time; the index walks up from zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_rd_req  <= 1'b0;
      nv_rd_addr <= '0;
    end else begin
      nv_rd_req <= (state_next == ST_LOAD_REQ);
      if (state_next == ST_POR) begin
        nv_rd_addr <= '0;
      end else if (state_reg == ST_LOAD_WAIT && nv_rd_valid && nv_rd_addr != IDX_LAST) begin
        nv_rd_addr <= nv_rd_addr + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command filter
  // ----------------------------------------------------------------------
  // Writes are taken only in digital run, on an enabled interface, at its
  // own effective address; the enable pin plays no part here
  always_comb begin
    cmd_ok = 1'b0;
    if (state_reg == ST_RUN && !analog_mode) begin
      if (cmd.iface == IF_I2C) begin
        cmd_ok = i2c_comm_en && (cmd.addr == i2c_addr_eff);
      end else begin
        cmd_ok = pmbus_comm_en && (cmd.addr == pmbus_addr_eff);
      end
    end
    cmd_ok = cmd_ok && cmd.sel <= IDX_LAST;
  end

  // Answer pulses for the bus engine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_ack    <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_ack    <= cmd_valid && cmd_ok;
      cmd_reject <= cmd_valid && !cmd_ok;
    end
  end

  // Load words and accepted commands share one write path
  always_comb begin
    wr_en   = 1'b0;
    wr_sel  = nv_rd_addr;
    wr_data = nv_rd_data;
    if (state_reg == ST_LOAD_WAIT && nv_rd_valid) begin
      wr_en = 1'b1;
    end else if (cmd_valid && cmd_ok) begin
      wr_en   = 1'b1;
      wr_sel  = cmd.sel;
      wr_data = cmd.data;
    end
  end

  // ----------------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------------
  // Defaults stand until the store overwrites them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      i2c_base_reg   <= I2C_BASE_RST;
      pmbus_base_reg <= PMBUS_BASE_RST;
      thr            <= '{VIN_ON_RST, VIN_OFF_RST, VIN_OV_RST, VIN_UV_RST};
      en_opt_reg     <= EN_OPT_RST;
    end else if (wr_en) begin
      case (wr_sel)
        IDX_I2C_BASE:   i2c_base_reg   <= wr_data[6:0];
        IDX_PMBUS_BASE: pmbus_base_reg <= wr_data[6:0];
        IDX_VIN_ON:     thr.vin_on     <= wr_data;
        IDX_VIN_OFF:    thr.vin_off    <= wr_data;
        IDX_VIN_OV:     thr.vin_ov     <= wr_data;
        IDX_VIN_UV:     thr.vin_uv     <= wr_data;
        IDX_EN_OPT:     en_opt_reg     <= wr_data;
        default:        en_opt_reg     <= en_opt_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Offset and mode latch
  // ----------------------------------------------------------------------
  // Caught once when the reading arrives; the pin is not read again, so a
  // resistor swapped later has no effect until the next power-up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      offset_reg  <= 4'h0;
      analog_mode <= 1'b0;
      addr_read   <= 1'b0;
      load_done   <= 1'b0;
    end else if (state_next == ST_POR) begin
      offset_reg  <= 4'h0;
      analog_mode <= 1'b0;
      addr_read   <= 1'b0;
      load_done   <= 1'b0;
    end else begin
      if (state_reg == ST_LOAD_WAIT && state_next == ST_ADC_REQ) begin
        load_done <= 1'b1;
      end
      if (state_reg == ST_ADC_WAIT && adc_valid) begin
        offset_reg  <= dec_offset;
        analog_mode <= dec_float;
        addr_read   <= 1'b1;
      end
    end
  end

  // Offset pin conversion request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= (state_next == ST_ADC_REQ);
    end
  end

  // ----------------------------------------------------------------------
  // Effective addresses
  // ----------------------------------------------------------------------
  // Base plus offset wraps within seven bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      i2c_addr_eff     <= '0;
      pmbus_addr_eff   <= '0;
      i2c_comm_en      <= 1'b0;
      pmbus_comm_en    <= 1'b0;
      comm_pins_analog <= 1'b0;
    end else begin
      i2c_addr_eff     <= i2c_base_reg + {3'h0, offset_reg};
      pmbus_addr_eff   <= pmbus_base_reg + {3'h0, offset_reg};
      i2c_comm_en      <= addr_read && !analog_mode && (i2c_base_reg != 7'h00);
      pmbus_comm_en    <= addr_read && !analog_mode && (pmbus_base_reg != 7'h00);
      comm_pins_analog <= addr_read && analog_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Input monitoring
  // ----------------------------------------------------------------------
  // Hysteresis comes from the two comparators; the digitised reading is
  // kept out of this path on purpose
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vin_ok_reg           <= 1'b0;
      undervoltage_lockout <= 1'b1;
      vin_ov_fault         <= 1'b0;
      vin_uv_warn          <= 1'b0;
    end else begin
      if (cmp_s[3]) begin
        vin_ok_reg <= 1'b1;
      end else if (cmp_s[2]) begin
        vin_ok_reg <= 1'b0;
      end
      undervoltage_lockout <= !vin_ok_reg;
      vin_ov_fault         <= cmp_s[1];
      vin_uv_warn          <= cmp_s[0];
    end
  end

  // Telemetry register only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      read_vin <= '0;
    end else if (vin_adc_valid) begin
      read_vin <= vin_adc_code;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion enable
  // ----------------------------------------------------------------------
  // Software options only count in digital mode
  always_comb begin
    if (!analog_mode && en_opt_reg[EN_SW_SEL_BIT]) begin
      run_conv = vin_ok_reg && load_done && addr_read && en_opt_reg[EN_SW_ON_BIT]
                 && (en_opt_reg[EN_PIN_IGN_BIT] || cmp_s[4]);
    end else begin
      run_conv = cmp_s[4] && vin_ok_reg && load_done && addr_read;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_enable <= 1'b0;
    end else begin
      conv_enable <= run_conv && (state_reg == ST_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_load_end;
    state_reg == ST_LOAD_WAIT && nv_rd_valid && nv_rd_addr == IDX_LAST;
  endsequence

  sequence s_adc_end;
    state_reg == ST_ADC_WAIT && adc_valid && supplies_good;
  endsequence

  a_por_holds: assert property (@(posedge core_clk) disable iff (rst)
    !supplies_good |=> por_active && state_reg == ST_POR)
    else $error("reset released with a monitor bad");

  a_load_first: assert property (@(posedge core_clk) disable iff (rst)
    adc_start |-> load_done)
    else $error("offset read before load finished");

  a_load_done: assert property (@(posedge core_clk) disable iff (rst)
    s_load_end ##0 supplies_good |=> load_done && adc_start)
    else $error("load end not followed by offset read");

  a_cmd_write: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_ok && cmd.sel == IDX_VIN_ON && !(state_reg == ST_LOAD_WAIT)
    |=> cmd_ack && thr.vin_on == $past(cmd.data))
    else $error("accepted write not stored");

  a_conv_gate: assert property (@(posedge core_clk) disable iff (rst)
    conv_enable && !$past(en_opt_reg[EN_SW_SEL_BIT])
    |-> $past(cmp_s[4] && vin_ok_reg && load_done && addr_read))
    else $error("conversion enabled without all conditions");

  a_zero_base: assert property (@(posedge core_clk) disable iff (rst)
    i2c_base_reg == 7'h00 |=> !i2c_comm_en)
    else $error("interface enabled with zero base");

  // The edge that releases reset still holds reset values, so the sum is
  // only compared from the edge after it
  a_addr_sum: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> pmbus_addr_eff == 7'($past(pmbus_base_reg) + {3'h0, $past(offset_reg)}))
    else $error("effective address wrong");

  a_analog_mute: assert property (@(posedge core_clk) disable iff (rst)
    analog_mode && cmd_valid |=> cmd_reject && !cmd_ack)
    else $error("command taken in analog mode");

  a_mode_latch: assert property (@(posedge core_clk) disable iff (rst)
    addr_read && supplies_good && $past(addr_read) |-> $stable(offset_reg) && $stable(analog_mode))
    else $error("offset changed after latch");

  a_offset_take: assert property (@(posedge core_clk) disable iff (rst)
    s_adc_end |=> addr_read && offset_reg == $past(dec_offset) ##2 conv_enable == $past(run_conv))
    else $error("offset not captured");

endmodule

// *** sim/scas_nv_adc_model.sv ***
// Model of the configuration store and offset pin ADC seen by the block
`timescale 1ns/1ps
module scas_nv_adc_model
  import scas_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Store port
  input  wire logic             nv_rd_req,
  input  wire logic [NV_AW-1:0] nv_rd_addr,
  output logic                  nv_rd_valid,
  output logic      [NV_DW-1:0] nv_rd_data,
  // Offset pin ADC
  input  wire logic             adc_start,
  input  wire logic [ADC_W-1:0] adc_set,
  output logic                  adc_valid,
  output logic      [ADC_W-1:0] adc_code
);
  // ----------------------------------------------------------------------
  // Store answers late on odd words so both delays are exercised
  // ----------------------------------------------------------------------
  logic [2:0]       nv_wait; // Cycles left before the answer
  logic [NV_AW-1:0] nv_idx;  // Word being fetched
  logic [7:0]       words [7];
  assign words = '{8'h10, 8'h40, 8'h31, 8'h2b, 8'hc8, 8'h11, 8'h00};
  // Idle data toggles so a stale word can never pass for a fresh one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_wait     <= 3'h0;
      nv_idx      <= '0;
      nv_rd_valid <= 1'b0;
      nv_rd_data  <= 8'h00;
      adc_valid   <= 1'b0;
      adc_code    <= 10'h000;
    end else begin
      nv_rd_valid <= 1'b0;
      nv_rd_data  <= ~nv_rd_data;
      adc_valid   <= adc_start;
      adc_code    <= adc_start ? adc_set : ~adc_code;
      if (nv_rd_req) begin
        nv_wait <= nv_rd_addr[0] ? 3'h4 : 3'h1;
        nv_idx  <= nv_rd_addr;
      end else if (nv_wait == 3'h1) begin
        nv_rd_valid <= 1'b1;
        nv_rd_data  <= words[nv_idx];
        nv_wait     <= 3'h0;
      end else if (nv_wait != 3'h0) begin
        nv_wait <= nv_wait - 3'h1;
      end
    end
  end
endmodule

// *** sim/startup_config_and_address_select_tb.sv ***
// Self-checking bench for start-up sequencing and address select
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module startup_config_and_address_select_tb;
  import scas_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic core_clk = 0, rst = 1, bias_supply_ok = 1, internal_core_supply_ok = 1, osc_stable = 0;
  logic enable_force_ccm_pin_cmp = 0, vin_above_on_cmp = 0, vin_below_off_cmp = 0;
  logic vin_ov_cmp = 0, vin_uv_warn_cmp = 0, vin_adc_valid = 0, cmd_valid = 0;
  logic nv_rd_req, nv_rd_valid, adc_start, adc_valid, cmd_ack, cmd_reject;
  logic [NV_AW-1:0] nv_rd_addr;
  logic [NV_DW-1:0] nv_rd_data;
  logic [ADC_W-1:0] adc_code, read_vin, adc_set = 0, vin_adc_code = 0;
  scas_cmd_s        cmd = '0;
  scas_thr_s        thr;
  logic por_active, load_done, addr_read, analog_mode, comm_pins_analog, i2c_comm_en;
  logic pmbus_comm_en, undervoltage_lockout, vin_ov_fault, vin_uv_warn, conv_enable;
  logic [6:0]       i2c_addr_eff, pmbus_addr_eff;
  int               fail_count = 0, total_checks = 0;
  logic [9:0]       codes [3] = '{10'h03b, 10'h03c, 10'h3bf}; // Bin edges
  logic [6:0]       eaddr [3] = '{7'h10, 7'h11, 7'h1f};
  scas_top dut_u (.*);
  scas_nv_adc_model model_u (.*);
  always #12.5 core_clk = ~core_clk;
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Reset held 2 cycles; oscillator late so the hold can be seen
  task automatic power_up(input logic [9:0] code);
    rst <= 1; osc_stable <= 0; adc_set <= code;
    tick(2); rst <= 0; tick(8);
    `CHK("por_active", 1'b1, por_active)
    `CHK("load_done", 1'b0, load_done)
    osc_stable <= 1;
    for (int i = 0; i < 300 && addr_read !== 1'b1; i++) tick(1);
    tick(3);
    `CHK("load_done", 1'b1, load_done)
    `CHK("addr_read", 1'b1, addr_read)
    `CHK("por_active", 1'b0, por_active)
  endtask
  task automatic send(input scas_iface_e f, input logic [6:0] a, input logic [2:0] s,
                      input logic [7:0] d, input logic ok);
    cmd_valid <= 1; cmd <= '{f, a, s, d};
    tick(1); cmd_valid <= 0; #1;
    `CHK("cmd_ack", ok, cmd_ack)
    `CHK("cmd_reject", ~ok, cmd_reject)
    tick(2);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    power_up(10'h12c);
    `CHK("thr", {8'h31, 8'h2b, 8'hc8, 8'h11}, thr)
    `CHK("i2c_addr", 7'h15, i2c_addr_eff)
    `CHK("pmbus_addr", 7'h45, pmbus_addr_eff)
    `CHK("i2c_en", 1'b1, i2c_comm_en)
    enable_force_ccm_pin_cmp <= 1; tick(6);
    `CHK("conv_enable", 1'b0, conv_enable)
    vin_above_on_cmp <= 1; vin_ov_cmp <= 1; vin_adc_valid <= 1; vin_adc_code <= 10'h3ff;
    vin_uv_warn_cmp <= 1;
    tick(1); vin_adc_valid <= 0; tick(6);
    `CHK("conv_enable", 1'b1, conv_enable)
    `CHK("ov_fault", 1'b1, vin_ov_fault)
    `CHK("uv_warn", 1'b1, vin_uv_warn)
    `CHK("read_vin", 10'h3ff, read_vin)
    vin_above_on_cmp <= 0; vin_below_off_cmp <= 1; tick(6);
    `CHK("lockout", 1'b1, undervoltage_lockout)
    `CHK("conv_enable", 1'b0, conv_enable)
    enable_force_ccm_pin_cmp <= 0;
    send(IF_I2C, 7'h15, IDX_VIN_ON, 8'h55, 1'b1);
    `CHK("vin_on", 8'h55, thr.vin_on)
    send(IF_I2C, 7'h16, IDX_VIN_ON, 8'h66, 1'b0);
    send(IF_PMBUS, 7'h45, IDX_I2C_BASE, 8'h20, 1'b1);
    `CHK("i2c_addr", 7'h25, i2c_addr_eff)
    send(IF_PMBUS, 7'h45, IDX_PMBUS_BASE, 8'h00, 1'b1);
    `CHK("pmbus_en", 1'b0, pmbus_comm_en)
    send(IF_PMBUS, 7'h05, IDX_VIN_ON, 8'h66, 1'b0);
    // Software enable on with the pin low; both comparators high, set wins
    send(IF_I2C, 7'h25, IDX_EN_OPT, 8'h07, 1'b1);
    vin_above_on_cmp <= 1; tick(6);
    `CHK("conv_enable", 1'b1, conv_enable)
    send(IF_I2C, 7'h25, IDX_EN_OPT, 8'h01, 1'b1);
    `CHK("conv_enable", 1'b0, conv_enable)
    send(IF_I2C, 7'h25, IDX_I2C_BASE, 8'h00, 1'b1);
    `CHK("i2c_en", 1'b0, i2c_comm_en)
    for (int k = 0; k < 3; k++) begin
      power_up(codes[k]);
      `CHK("i2c_addr", eaddr[k], i2c_addr_eff)
    end
    power_up(FLOAT_CODE);
    `CHK("analog_mode", 1'b1, analog_mode)
    `CHK("pins_analog", 1'b1, comm_pins_analog)
    send(IF_I2C, 7'h10, IDX_VIN_ON, 8'h77, 1'b0);
    `CHK("vin_on", 8'h31, thr.vin_on)
    tally_and_finish();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200us;
    fail_count++;
    tally_and_finish();
  end
endmodule
